// ==== dac_spi_pkg.sv ====
// Constants and types shared by the serial frame diagnostics block.
package dac_spi_pkg;
  localparam logic [5:0] LEN_FULL   = 6'h20;
  localparam logic [5:0] LEN_SHORT  = 6'h18;
  localparam logic [5:0] CNT_MAX    = 6'h3F;
  localparam logic [7:0] CRC_POLY   = 8'h07;
  localparam logic [7:0] CRC_INIT   = 8'h00;
  localparam logic [1:0] RB_SYNC    = 2'h2;
  localparam logic [4:0] SPI_NOP    = 5'h00;
  localparam logic [4:0] SPI_RB_SEL = 5'h01;
  localparam logic [4:0] SPI_DIAG   = 5'h02;
  localparam logic [4:0] SPI_STATUS = 5'h03;
  localparam logic [4:0] SPI_CONFIG = 5'h04;
  localparam int         FLAG_CRC   = 0;
  localparam int         FLAG_SLIP  = 1;
  localparam int         FLAG_SCLK  = 2;
  localparam int         CFG_CRC_EN = 0;
  localparam int         CFG_MODE   = 1;
  localparam int         CFG_FLT    = 3;
  localparam logic [3:0] CFG_RESET  = 4'h9;
  localparam logic [7:0] AX_CONFIG  = 8'h00;
  localparam logic [7:0] AX_DIAG    = 8'h04;
  localparam logic [7:0] AX_STATUS  = 8'h08;
  localparam logic [7:0] AX_LAST    = 8'h0C;
  localparam logic [7:0] AX_ARRAY   = 8'h80;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RB_TWO_STAGE   = 2'h0,
    RB_AUTO        = 2'h1,
    RB_AUTO_SHARED = 2'h2,
    RB_ECHO        = 2'h3
  } rb_mode_t;
endpackage : dac_spi_pkg

// ==== spi_fe_if.sv ====
// Signals between the serial front end and the frame checker.
`timescale 1ns/1ps
`default_nettype none
interface spi_fe_if;
  logic        frame_start;
  logic        frame_end;
  logic [31:0] rx_word;
  logic [5:0]  edge_cnt;
  logic [31:0] tx_word;
  logic        tx_drive;
  logic        sdo;
  logic        sdo_oe;
  modport fe (output frame_start, output frame_end, output rx_word, output edge_cnt,
              output sdo, output sdo_oe, input tx_word, input tx_drive);
  modport core (input frame_start, input frame_end, input rx_word, input edge_cnt,
                input sdo, input sdo_oe, output tx_word, output tx_drive);
endinterface : spi_fe_if
`default_nettype wire

// ==== spi_frame_rx.sv ====
// Serial front end: pin synchronisers, edge detection, shift in and shift out.
`timescale 1ns/1ps
`default_nettype none
module spi_frame_rx
  import dac_spi_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic sclk,
  input  wire logic frame_sel_n,
  input  wire logic sdi,
  spi_fe_if.fe      link
);
  typedef struct packed {
    logic        sclk_s1;
    logic        sclk_s2;
    logic        sclk_d;
    logic        cs_s1;
    logic        cs_s2;
    logic        cs_d;
    logic        sdi_s1;
    logic        sdi_s2;
    logic        in_frame;
    logic        start;
    logic        done;
    logic [31:0] shin;
    logic [5:0]  cnt;
    logic [31:0] shout;
    logic        oe;
  } fe_t;

  fe_t st_r;
  fe_t st_nxt;
  logic fall;
  logic rise;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sclk_s1 = sclk;
    st_nxt.sclk_s2 = st_r.sclk_s1;
    st_nxt.sclk_d  = st_r.sclk_s2;
    st_nxt.cs_s1   = frame_sel_n;
    st_nxt.cs_s2   = st_r.cs_s1;
    st_nxt.cs_d    = st_r.cs_s2;
    st_nxt.sdi_s1  = sdi;
    st_nxt.sdi_s2  = st_r.sdi_s1;
    fall = st_r.sclk_d & ~st_r.sclk_s2;
    rise = ~st_r.sclk_d & st_r.sclk_s2;
    st_nxt.start = st_r.cs_d & ~st_r.cs_s2;
    st_nxt.done  = ~st_r.cs_d & st_r.cs_s2 & st_r.in_frame;
    if (st_nxt.start) begin
      st_nxt.in_frame = 1'b1;
      st_nxt.cnt      = '0;
      st_nxt.shin     = '0;
    end else if (st_r.in_frame && !st_r.cs_s2 && fall) begin
      st_nxt.shin = {st_r.shin[30:0], st_r.sdi_s2};
      if (st_r.cnt != CNT_MAX) begin
        st_nxt.cnt = st_r.cnt + 6'h01;
      end
    end
    if (st_r.start) begin
      st_nxt.shout = link.tx_word;
      st_nxt.oe    = link.tx_drive;
    end else if (st_r.in_frame && rise) begin
      // Bits change on the rising edge so the controller samples them stable on the fall.
      st_nxt.shout = {st_r.shout[30:0], 1'b0};
    end
    if (st_nxt.done) begin
      st_nxt.in_frame = 1'b0;
      st_nxt.oe       = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r       <= '0;
      st_r.cs_s1 <= 1'b1;
      st_r.cs_s2 <= 1'b1;
      st_r.cs_d  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.frame_start = st_r.start;
  assign link.frame_end   = st_r.done;
  assign link.rx_word     = st_r.shin;
  assign link.edge_cnt    = st_r.cnt;
  assign link.sdo         = st_r.shout[31];
  assign link.sdo_oe      = st_r.oe;
endmodule : spi_frame_rx
`default_nettype wire

// ==== dac_spi_frame_diagnostics.sv ====
// Frame checker, diagnostic flags, readback and register bus of the serial port.
// Summary of operation
// - With checking on, 32-bit words shift in MSB first, captured on SCLK fall.
// - Each serial bit is sampled on SCLK falling edge while select is low.
// - With checking off, payload is 24 bits; 32-bit frames drop the last 8.
// - Frame: bit 31 slip, 30-29 device address, 28-24 register, 23-8 data, 7-0 check.
// - A frame is taken only if its address bits equal the two strap pins.
// - Good check writes the register; bad check discards, faults, sets CRC flag.
// - Flags clear by writing one; clearing bit 0 releases fault if nothing else.
// - A configuration bit decides whether a CRC error drives the fault output.
// - Outgoing frames on SDO carry the same CRC-8 check byte.
// - Bit 31 must invert bit 30; otherwise discard and set slip flag.
// - Falling SCLK edges are counted; wrong lengths are discarded, flagged.
// - Four readback modes: two-stage, auto status, shared-select status, echo.
// - Two-stage: write readback select, then a NOP frame shifts the register out.
// - Readback frame: 0b10, fault status, address, data, check byte.
// - Auto status puts status on every frame, off at reset, no two-stage.
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dac_spi_frame_diagnostics
  import dac_spi_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        sclk,
  input  wire logic        frame_sel_n,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe,
  input  wire logic        dev_addr_strap_lo,
  input  wire logic        dev_addr_strap_hi,
  output logic             fault_n
);
  typedef struct packed {
    logic [1:0]        strap_s1;
    logic [1:0]        strap_s2;
    logic              crc_en;
    rb_mode_t          rb_mode;
    logic              fault_crc;
    logic [2:0]        digital_diag_result_flags;
    logic [31:0][15:0] regs;
    logic [4:0]        rb_sel;
    logic              rb_pend;
    logic              echo_phase;
    logic              hit_prev;
    logic [20:0]       last_cmd;
    logic              fault_out;
    logic              aw_have;
    logic [7:0]        aw_addr;
    logic              w_have;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } core_t;

  core_t st_r;
  core_t st_nxt;

  spi_fe_if link ();

  spi_frame_rx u_rx (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .sclk        (sclk),
    .frame_sel_n (frame_sel_n),
    .sdi         (sdi),
    .link        (link)
  );

  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 23; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction : crc8

  function automatic logic fault_on(input core_t s);
    return s.fault_crc & s.digital_diag_result_flags[FLAG_CRC];
  endfunction : fault_on

  function automatic logic [15:0] reg_value(input core_t s, input logic [4:0] a);
    logic [15:0] v;
    v = s.regs[a];
    case (a)
      SPI_DIAG:   v = {13'h0000, s.digital_diag_result_flags};
      SPI_STATUS: v = {14'h0000, |s.digital_diag_result_flags, fault_on(s)};
      SPI_CONFIG: v = {12'h000, s.fault_crc, s.rb_mode, s.crc_en};
      SPI_RB_SEL: v = {11'h000, s.rb_sel};
      default:    v = s.regs[a];
    endcase
    return v;
  endfunction : reg_value

  function automatic logic axi_mapped(input logic [7:0] a);
    return a[7] | (a[6:2] <= AX_LAST[6:2]);
  endfunction : axi_mapped

  function automatic logic [31:0] axi_value(input core_t s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h00000000;
    if (a[7] == AX_ARRAY[7]) begin
      v = {16'h0000, s.regs[a[6:2]]};
    end else if (a[6:2] == AX_CONFIG[6:2]) begin
      v = {16'h0000, reg_value(s, SPI_CONFIG)};
    end else if (a[6:2] == AX_DIAG[6:2]) begin
      v = {16'h0000, reg_value(s, SPI_DIAG)};
    end else if (a[6:2] == AX_STATUS[6:2]) begin
      v = {16'h0000, reg_value(s, SPI_STATUS)};
    end else if (a[6:2] == AX_LAST[6:2]) begin
      v = {11'h000, s.last_cmd};
    end
    return v;
  endfunction : axi_value

  logic [23:0] payload;
  logic        len_full;
  logic        len_ok;
  logic        addr_ok;
  logic        slip_ok;
  logic        crc_ok;
  logic        accept;
  logic [2:0]  flag_set;
  logic [2:0]  flag_clr;
  logic [4:0]  tx_addr;
  logic [15:0] tx_data;
  logic [23:0] tx_head;
  logic [4:0]  rx_reg;
  logic [15:0] rx_data;

  always_comb begin
    st_nxt   = st_r;
    flag_set = 3'h0;
    flag_clr = 3'h0;
    st_nxt.strap_s1 = {dev_addr_strap_hi, dev_addr_strap_lo};
    st_nxt.strap_s2 = st_r.strap_s1;

    // Frame qualification; a 24-edge frame is legal only while checking is off.
    len_full = link.edge_cnt == LEN_FULL;
    len_ok   = len_full | (!st_r.crc_en && link.edge_cnt == LEN_SHORT);
    payload  = len_full ? link.rx_word[31:8] : link.rx_word[23:0];
    rx_reg   = payload[20:16];
    rx_data  = payload[15:0];
    addr_ok  = payload[22:21] == st_r.strap_s2;
    slip_ok  = payload[23] != payload[22];
    crc_ok   = !st_r.crc_en || crc8(payload) == link.rx_word[7:0];
    accept   = len_ok & addr_ok & slip_ok & crc_ok;

    // Readback word for the frame that is starting.
    tx_addr = st_r.rb_sel;
    tx_data = reg_value(st_r, st_r.rb_sel);
    link.tx_drive = st_r.rb_pend;
    unique case (st_r.rb_mode)
      RB_TWO_STAGE: begin
        link.tx_drive = st_r.rb_pend;
      end
      RB_AUTO: begin
        tx_addr = SPI_STATUS;
        tx_data = reg_value(st_r, SPI_STATUS);
        link.tx_drive = 1'b1;
      end
      RB_AUTO_SHARED: begin
        // Drive only after a frame meant for this device, so shared-select parts never clash.
        tx_addr = SPI_STATUS;
        tx_data = reg_value(st_r, SPI_STATUS);
        link.tx_drive = st_r.hit_prev;
      end
      RB_ECHO: begin
        tx_addr = st_r.echo_phase ? st_r.last_cmd[20:16] : SPI_STATUS;
        tx_data = st_r.echo_phase ? st_r.last_cmd[15:0] : reg_value(st_r, SPI_STATUS);
        link.tx_drive = 1'b1;
      end
    endcase
    tx_head      = {RB_SYNC, fault_on(st_r), tx_addr, tx_data};
    link.tx_word = {tx_head, crc8(tx_head)};

    if (link.frame_start) begin
      st_nxt.rb_pend    = 1'b0;
      st_nxt.echo_phase = (st_r.rb_mode == RB_ECHO) ? ~st_r.echo_phase : 1'b0;
    end

    // Register bus write, performed once address and data are both held.
    if (st_r.aw_have && st_r.w_have) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = axi_mapped(st_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (st_r.w_strb[0] && st_r.aw_addr[7:2] == AX_CONFIG[7:2]) begin
        st_nxt.crc_en    = st_r.w_data[CFG_CRC_EN];
        st_nxt.rb_mode   = rb_mode_t'(st_r.w_data[CFG_MODE +: 2]);
        st_nxt.fault_crc = st_r.w_data[CFG_FLT];
      end
      if (st_r.w_strb[0] && st_r.aw_addr[7:2] == AX_DIAG[7:2]) begin
        flag_clr = st_r.w_data[2:0];
      end
    end

    if (link.frame_end) begin
      st_nxt.hit_prev = len_ok & addr_ok;
      flag_set[FLAG_SCLK] = !len_ok;
      flag_set[FLAG_SLIP] = len_ok & addr_ok & !slip_ok;
      flag_set[FLAG_CRC]  = len_ok & addr_ok & !crc_ok;
      if (accept) begin
        st_nxt.last_cmd = payload[20:0];
        case (rx_reg)
          SPI_NOP, SPI_STATUS: begin
          end
          SPI_RB_SEL: begin
            st_nxt.rb_sel  = rx_data[4:0];
            st_nxt.rb_pend = 1'b1;
          end
          SPI_DIAG: begin
            flag_clr = flag_clr | rx_data[2:0];
          end
          SPI_CONFIG: begin
            st_nxt.crc_en    = rx_data[CFG_CRC_EN];
            st_nxt.rb_mode   = rb_mode_t'(rx_data[CFG_MODE +: 2]);
            st_nxt.fault_crc = rx_data[CFG_FLT];
          end
          default: begin
            st_nxt.regs[rx_reg] = rx_data;
          end
        endcase
      end
    end
    // A new error in the same cycle as its clear survives the clear.
    st_nxt.digital_diag_result_flags =
      (st_r.digital_diag_result_flags & ~flag_clr) | flag_set;
    st_nxt.fault_out = fault_on(st_nxt);

    if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (awvalid && awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.w_data = wdata;
      st_nxt.w_strb = wstrb;
    end
    if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = axi_value(st_r, araddr);
      st_nxt.rresp  = axi_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r           <= '0;
      st_r.crc_en    <= CFG_RESET[CFG_CRC_EN];
      st_r.rb_mode   <= RB_TWO_STAGE;
      st_r.fault_crc <= CFG_RESET[CFG_FLT];
    end else begin
      st_r <= st_nxt;
    end
  end

  // One write and one read at a time; ready stays low while a response waits.
  assign awready = !st_r.aw_have && !st_r.bvalid;
  assign wready  = !st_r.w_have && !st_r.bvalid;
  assign arready = !st_r.rvalid;
  assign bvalid  = st_r.bvalid;
  assign bresp   = st_r.bresp;
  assign rvalid  = st_r.rvalid;
  assign rdata   = st_r.rdata;
  assign rresp   = st_r.rresp;
  assign sdo     = link.sdo;
  assign sdo_oe  = link.sdo_oe;
  assign fault_n = !st_r.fault_out;
endmodule : dac_spi_frame_diagnostics
`default_nettype wire

// ==== dac_spi_assertions.sv ====
// Concurrent checks on the ports of the serial frame diagnostics block.
`timescale 1ns/1ps
`default_nettype none
module dac_spi_assertions (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        sclk,
  input wire logic        frame_sel_n,
  input wire logic        sdo,
  input wire logic        sdo_oe,
  input wire logic        fault_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence sel_idle;
    frame_sel_n [*6];
  endsequence
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response changed before it was taken");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before it was taken");
  a_arready_gate: assert property (arready == !rvalid)
    else $error("read address ready does not follow read valid");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_write_answer: assert property (wr_take |=> !bvalid ##1 bvalid)
    else $error("write answer not two cycles after the take");
  a_fault_after_frame: assert property (
    $fell(fault_n) |-> frame_sel_n && $past(frame_sel_n, 3))
    else $error("fault output fell outside frame evaluation");
  a_oe_in_frame: assert property ($rose(sdo_oe) |-> !frame_sel_n)
    else $error("serial output driven outside a frame");
  a_oe_release: assert property (sel_idle |-> !sdo_oe)
    else $error("serial output still driven after the frame");
  a_sdo_steady: assert property ($fell(sclk) && sdo_oe |=> $stable(sdo) [*3])
    else $error("serial output moved around the capture edge");
endmodule : dac_spi_assertions
bind dac_spi_frame_diagnostics dac_spi_assertions i_chk (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
  .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .sclk,
  .frame_sel_n, .sdo, .sdo_oe, .fault_n
);
`default_nettype wire

// ==== spi_ctl_model.sv ====
// Serial controller model driving frames into the block.
`timescale 1ns/1ps
`default_nettype none
module spi_ctl_model (
  input  wire logic aclk,
  output logic      sclk,
  output logic      frame_sel_n,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  // The clock idles high and stands still between frames.
  initial begin
    sclk = 1'b1;
    frame_sel_n = 1'b1;
    sdi = 1'b0;
  end
  task automatic xfer(input logic [31:0] w, input int n, input int lead,
                      output logic [31:0] rx);
    logic [31:0] s;
    s = w;
    rx = 32'h0;
    @(posedge aclk);
    frame_sel_n <= 1'b0;
    repeat (lead) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      sdi <= s[31];
      s = {s[30:0], 1'b0};
      repeat (4) @(posedge aclk);
      sclk <= 1'b0;
      repeat (4) @(posedge aclk);
      rx = {rx[30:0], sdo_oe ? sdo : 1'b0};
      sclk <= 1'b1;
    end
    repeat (4) @(posedge aclk);
    frame_sel_n <= 1'b1;
    sdi <= ~sdi;
    repeat (16) @(posedge aclk);
  endtask : xfer
endmodule : spi_ctl_model
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the serial frame diagnostics block.
`timescale 1ns/1ps
`default_nettype none
module tb
  import dac_spi_pkg::*;
();
  localparam logic [1:0] ADR = 2'h2;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        sclk, frame_sel_n, sdi, sdo, sdo_oe, fault_n;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rx;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  int          checks, failures;

  dac_spi_frame_diagnostics i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .sclk, .frame_sel_n, .sdi, .sdo,
    .sdo_oe, .dev_addr_strap_lo(ADR[0]), .dev_addr_strap_hi(ADR[1]), .fault_n);
  spi_ctl_model i_ctl (.aclk, .sclk, .frame_sel_n, .sdi, .sdo, .sdo_oe);

  always #12.5 aclk = ~aclk;

  function automatic logic [7:0] crc8(input logic [23:0] p);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ p[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction : crc8
  function automatic logic [31:0] frm(input logic s, input logic [1:0] a,
                                      input logic [4:0] r, input logic [15:0] d);
    logic [23:0] p;
    p = {s ^ ~a[1], a, r, d};
    return {p, crc8(p)};
  endfunction : frm
  function automatic logic [31:0] rbx(input logic [4:0] r, input logic [15:0] d);
    logic [23:0] p;
    p = {RB_SYNC, 1'b0, r, d};
    return {p, crc8(p)};
  endfunction : rbx

  task automatic end_sim;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    axi_rd(a, d, rs);
    chk(d, e);
  endtask : rchk
  task automatic fchk(input logic e);
    chk({31'h0, fault_n}, {31'h0, e});
  endtask : fchk
  // The fault output is registered from the flags, so allow it to settle.
  task automatic clr(input logic [31:0] v);
    axi_wr(AX_DIAG, v, rs);
    repeat (2) @(posedge aclk);
  endtask : clr
  task automatic ser(input logic [31:0] w, input int n);
    i_ctl.xfer(w, n, 8, rx);
  endtask : ser

  task automatic t_reset;
    rchk(AX_CONFIG, {28'h0, CFG_RESET});
    rchk(AX_DIAG, 32'h0);
    fchk(1'b1);
    axi_rd(8'h40, rx, rs);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    axi_wr(8'h44, 32'h1, rs);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
  endtask : t_reset
  task automatic t_write;
    i_ctl.xfer(frm(1'b0, ADR, 5'h05, 16'hA5C3), 32, 20, rx);
    rchk(AX_ARRAY + 8'h14, 32'hA5C3);
    rchk(AX_LAST, 32'h0005A5C3);
  endtask : t_write
  task automatic t_crc;
    ser(frm(1'b0, ADR, 5'h06, 16'h1234) ^ 32'h1, 32);
    rchk(AX_DIAG, 32'h1);
    rchk(AX_STATUS, 32'h3);
    rchk(AX_ARRAY + 8'h18, 32'h0);
    fchk(1'b0);
    clr(32'h1);
    fchk(1'b1);
    rchk(AX_DIAG, 32'h0);
  endtask : t_crc
  task automatic t_slip;
    ser(frm(1'b1, ADR, 5'h06, 16'h1234), 32);
    rchk(AX_DIAG, 32'h2);
    rchk(AX_ARRAY + 8'h18, 32'h0);
    fchk(1'b1);
    clr(32'h2);
  endtask : t_slip
  task automatic t_len;
    int ln [3];
    ln = '{24, 31, 33};
    foreach (ln[i]) begin
      ser(frm(1'b0, ADR, 5'h06, 16'h1234), ln[i]);
      rchk(AX_DIAG, 32'h4);
      rchk(AX_ARRAY + 8'h18, 32'h0);
      clr(32'h4);
    end
  endtask : t_len
  task automatic t_addr;
    for (int a = 0; a < 3; a++) begin
      ser(frm(1'b0, ADR ^ 2'(a + 1), 5'h06, 16'h00FF), 32);
      rchk(AX_DIAG, 32'h0);
      rchk(AX_ARRAY + 8'h18, 32'h0);
    end
  endtask : t_addr
  task automatic t_nocheck;
    axi_wr(AX_CONFIG, 32'h8, rs);
    ser(frm(1'b0, ADR, 5'h07, 16'h0777), 24);
    ser(frm(1'b0, ADR, 5'h08, 16'h0888) ^ 32'hFF, 32);
    rchk(AX_ARRAY + 8'h1C, 32'h0777);
    rchk(AX_ARRAY + 8'h20, 32'h0888);
    rchk(AX_DIAG, 32'h0);
    axi_wr(AX_CONFIG, 32'h1, rs);
    ser(frm(1'b0, ADR, 5'h09, 16'h0999) ^ 32'h1, 32);
    rchk(AX_DIAG, 32'h1);
    fchk(1'b1);
    clr(32'h1);
    axi_wr(AX_CONFIG, {28'h0, CFG_RESET}, rs);
  endtask : t_nocheck
  task automatic t_twostage;
    ser(frm(1'b0, ADR, SPI_RB_SEL, 16'h0005), 32);
    ser(frm(1'b0, ADR, SPI_NOP, 16'h0000), 32);
    chk(rx, rbx(5'h05, 16'hA5C3));
  endtask : t_twostage
  task automatic t_modes;
    for (int m = 1; m < 4; m++) begin
      axi_wr(AX_CONFIG, {28'h0, 1'b1, 2'(m), 1'b1}, rs);
      ser(frm(1'b0, ADR, SPI_RB_SEL, 16'h0005), 32);
      chk(rx, rbx(SPI_STATUS, 16'h0000));
      if (m == 1) begin
        ser(frm(1'b0, ADR, SPI_NOP, 16'h0000), 32);
        chk(rx, rbx(SPI_STATUS, 16'h0000));
      end
      // A frame for another device must silence the shared-select status output.
      if (m == 2) begin
        ser(frm(1'b0, ~ADR, SPI_NOP, 16'h0000), 32);
        chk(rx, rbx(SPI_STATUS, 16'h0000));
        ser(frm(1'b0, ADR, SPI_NOP, 16'h0000), 32);
        chk(rx, 32'h0);
      end
      if (m == 3) begin
        ser(frm(1'b0, ADR, SPI_NOP, 16'h0000), 32);
        chk(rx, rbx(SPI_RB_SEL, 16'h0005));
      end
    end
    axi_wr(AX_CONFIG, {28'h0, CFG_RESET}, rs);
  endtask : t_modes

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    checks = 0;
    failures = 0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    t_reset;
    t_write;
    t_crc;
    t_slip;
    t_len;
    t_addr;
    t_nocheck;
    t_twostage;
    t_modes;
    end_sim;
  end
  // Some twenty frames of about three hundred cycles each fit well inside this span.
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    end_sim;
  end
endmodule : tb
`default_nettype wire
